// ---- ism_pkg.sv ----
/*
  Shared constants, types and register map for the indicator status monitor.
  Assumes one 200 MHz clock and a 12-bit AXI4-Lite byte address space.
*/
`default_nettype none
package ism_pkg;
  localparam int N_IND       = 10;
  localparam int NAME_CHARS  = 32;
  localparam int NAME_WORDS  = NAME_CHARS / 4;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TS_RES_US     = 1000;
  localparam int TICK_CYCLES   = TS_RES_US * 1000 * 1000 / CLK_PERIOD_PS;

  localparam logic [11:0] A_CTRL      = 12'h000;
  localparam logic [11:0] A_SINGLE    = 12'h004;
  localparam logic [11:0] A_EVMASK    = 12'h008;
  localparam logic [11:0] A_STATUS    = 12'h00C;
  localparam logic [11:0] A_IRQ_STAT  = 12'h010;
  localparam logic [11:0] A_IRQ_MASK  = 12'h014;
  localparam logic [11:0] A_TIME      = 12'h018;
  localparam logic [11:0] A_NAME_BASE = 12'h100;
  localparam logic [11:0] A_NAME_END  = 12'h240;

  localparam int CTRL_SETUP_BIT = 0;
  localparam int IRQ_CHG_BIT    = 0;
  localparam int IRQ_BAD_BIT    = 1;
  localparam int IRQ_OVR_BIT    = 2;
  localparam int IRQ_W          = 3;

  localparam logic        CTRL_SETUP_RST = 1'h0;
  localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;
  localparam logic [31:0] DEFAULT_LABEL  = 32'h58646E49;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_INTER  = 2'b00,
    ST_OPEN   = 2'b01,
    ST_CLOSED = 2'b10,
    ST_BAD    = 2'b11
  } ism_status_e;

  typedef enum logic [1:0] {
    EM_IDLE = 2'b00,
    EM_OFF  = 2'b01,
    EM_ON   = 2'b10
  } ism_emit_e;

  typedef struct packed {
    logic [3:0]  inst;
    ism_status_e kind;
    logic        on;
    logic [31:0] stamp;
  } ism_evt_s;

  typedef struct packed {
    ism_status_e old_st;
    ism_status_e new_st;
    logic [31:0] stamp;
  } ism_rec_s;
endpackage
`default_nettype wire

// ---- ism_ms_tick.sv ----
/*
  Divider giving a one-cycle enable every DIV clocks.
  Assumes the single system clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ism_ms_tick #(
  parameter int DIV = ism_pkg::TICK_CYCLES
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output var  logic tick
);
  import ism_pkg::*;
  localparam int CW = $clog2(DIV);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_tick;

  always_comb begin
    next_tick = (cnt == CW'(DIV - 1));
    next_cnt  = next_tick ? '0 : cnt + CW'(1);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// ---- ism_decode.sv ----
/*
  One indicator: input selection, status decode, per-clock status register
  and change detection. Assumes inputs synchronous to aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module ism_decode (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 run,
  input  wire logic                 single,
  input  wire logic                 open_in,
  input  wire logic                 close_in,
  output var  ism_pkg::ism_status_e status,
  output var  ism_pkg::ism_status_e sample,
  output var  logic                 chg
);
  import ism_pkg::*;

  logic        primed;
  logic        next_primed;
  ism_status_e next_status;
  logic        close_sel;

  always_comb begin
    close_sel   = single ? ~open_in : close_in;
    sample      = ism_status_e'({close_sel, open_in});
    next_status = sample;
    next_primed = run;
    // no event until one sample has been registered after reset or setup
    chg         = run & primed & (sample != status);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      primed <= 1'b0;
      status <= ST_INTER;
    end else begin
      primed <= next_primed;
      status <= next_status;
    end
  end
endmodule
`default_nettype wire

// ---- ism_top.sv ----
/*
  Indicator status monitor: decodes open/close inputs of up to N_IND
  indicators, time stamps each status change at 1 ms and streams ON/OFF
  events toward the common event buffer; AXI4-Lite register slave.
  Assumes synchronous inputs and a downstream buffer with valid/ready.
*/
//
// Operation
// - open input high means open
// - close input high means closed
// - both inputs low reports Intermediate
// - both inputs high reports Bad
// - ON and OFF events per decoded status
// - time stamps count whole milliseconds
// - mask selects ON, OFF or both stored
// - observation only, no command outputs
// - single input mode uses inverted copy
// - settings changeable only during setup
// - per-instance name up to 32 characters
// - up to ten independent indicator instances
`timescale 1ns/1ps
`default_nettype none
module ism_top #(
  parameter int N_IND    = ism_pkg::N_IND,
  parameter int TICK_DIV = ism_pkg::TICK_CYCLES
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [N_IND-1:0]  open_in,
  input  wire logic [N_IND-1:0]  close_in,
  output var  logic              evt_valid,
  input  wire logic              evt_ready,
  output var  ism_pkg::ism_evt_s evt,
  output var  logic              irq
);
  import ism_pkg::*;
  localparam int NW = N_IND * NAME_WORDS;

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_name(input logic [11:0] a);
    return (a >= A_NAME_BASE) && (a < A_NAME_END);
  endfunction

  function automatic logic [6:0] name_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - A_NAME_BASE;
    return d[8:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // per-indicator decode
  ism_status_e      st      [N_IND];
  ism_status_e      smp     [N_IND];
  logic [N_IND-1:0] chg;
  logic             ctrl_setup;
  logic [N_IND-1:0] single;
  logic             tick;

  for (genvar g = 0; g < N_IND; g++) begin : g_ind
    ism_decode u_dec (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .run      (~ctrl_setup),
      .single   (single[g]),
      .open_in  (open_in[g]),
      .close_in (close_in[g]),
      .status   (st[g]),
      .sample   (smp[g]),
      .chg      (chg[g])
    );
  end

  ism_ms_tick #(.DIV(TICK_DIV)) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // change records and event emitter
  logic [N_IND-1:0] pend;
  logic [N_IND-1:0] next_pend;
  ism_rec_s         rec      [N_IND];
  ism_rec_s         next_rec [N_IND];
  ism_emit_e        em_st;
  ism_emit_e        next_em_st;
  ism_rec_s         cur;
  ism_rec_s         next_cur;
  logic [3:0]       cur_inst;
  logic [3:0]       next_cur_inst;
  logic             next_evt_valid;
  ism_evt_s         next_evt;
  logic [31:0]      ms;
  logic [31:0]      next_ms;
  logic [IRQ_W-1:0] ev_set;
  logic [2*N_IND-1:0] evmask;
  logic             any_pend;
  logic [3:0]       sel;

  always_comb begin
    next_pend      = pend;
    next_rec       = rec;
    next_em_st     = em_st;
    next_cur       = cur;
    next_cur_inst  = cur_inst;
    next_evt_valid = evt_valid;
    next_evt       = evt;
    next_ms        = tick ? ms + 32'h1 : ms;
    ev_set         = '0;
    any_pend       = |pend;
    sel            = '0;
    for (int i = N_IND - 1; i >= 0; i--) begin
      if (pend[i]) begin
        sel = 4'(i);
      end
    end
    // records are copied out at pick so a new change is never blocked
    unique case (em_st)
      EM_IDLE: begin
        if (any_pend) begin
          next_cur        = rec[sel];
          next_cur_inst   = sel;
          next_pend[sel]  = 1'b0;
          next_em_st      = EM_OFF;
        end
      end
      EM_OFF: begin
        if (evt_valid) begin
          if (evt_ready) begin
            next_evt_valid = 1'b0;
            next_em_st     = EM_ON;
          end
        end else if (evmask[2*cur_inst+1]) begin
          next_evt_valid = 1'b1;
          next_evt       = '{inst: cur_inst, kind: cur.old_st, on: 1'b0, stamp: cur.stamp};
        end else begin
          next_em_st = EM_ON;
        end
      end
      EM_ON: begin
        if (evt_valid) begin
          if (evt_ready) begin
            next_evt_valid = 1'b0;
            next_em_st     = EM_IDLE;
          end
        end else if (evmask[2*cur_inst]) begin
          next_evt_valid = 1'b1;
          next_evt       = '{inst: cur_inst, kind: cur.new_st, on: 1'b1, stamp: cur.stamp};
        end else begin
          next_em_st = EM_IDLE;
        end
      end
      default: begin
        next_em_st = EM_IDLE;
      end
    endcase
    // new change after the pick wins over the clear by the emitter
    for (int i = 0; i < N_IND; i++) begin
      if (chg[i]) begin
        ev_set[IRQ_CHG_BIT] = 1'b1;
        if (smp[i] == ST_BAD) begin
          ev_set[IRQ_BAD_BIT] = 1'b1;
        end
        if (next_pend[i]) begin
          // undrained record: merge, keep the old status, flag the loss
          next_rec[i].new_st  = smp[i];
          ev_set[IRQ_OVR_BIT] = 1'b1;
          if (smp[i] == rec[i].old_st) begin
            next_pend[i] = 1'b0;
          end
        end else begin
          next_pend[i] = 1'b1;
          next_rec[i]  = '{old_st: st[i], new_st: smp[i], stamp: ms};
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend      <= '0;
      em_st     <= EM_IDLE;
      cur       <= '0;
      cur_inst  <= '0;
      evt_valid <= 1'b0;
      evt       <= '0;
      ms        <= '0;
      for (int i = 0; i < N_IND; i++) begin
        rec[i] <= '0;
      end
    end else begin
      pend      <= next_pend;
      rec       <= next_rec;
      em_st     <= next_em_st;
      cur       <= next_cur;
      cur_inst  <= next_cur_inst;
      evt_valid <= next_evt_valid;
      evt       <= next_evt;
      ms        <= next_ms;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave and registers; nothing here drives the switchgear
  logic               aw_hold;
  logic               w_hold;
  logic [11:0]        aw_addr;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;
  logic [31:0]        name     [NW];
  logic [31:0]        next_name [NW];
  logic [IRQ_W-1:0]   irq_stat;
  logic [IRQ_W-1:0]   irq_mask;
  logic               next_aw_hold, next_w_hold, next_setup, next_irq;
  logic [11:0]        next_aw_addr;
  logic [31:0]        next_w_data, next_rdata, wv, rd;
  logic [3:0]         next_w_strb;
  logic [N_IND-1:0]   next_single;
  logic [2*N_IND-1:0] next_evmask;
  logic [IRQ_W-1:0]   next_irq_stat, next_irq_mask, w1c;
  logic [1:0]         next_bresp, next_rresp;
  logic               next_bvalid, next_rvalid, rd_ok;
  logic [31:0]        stat_word;

  always_comb begin
    next_aw_hold  = aw_hold;
    next_w_hold   = w_hold;
    next_aw_addr  = aw_addr;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_setup    = ctrl_setup;
    next_single   = single;
    next_evmask   = evmask;
    next_name     = name;
    next_irq_mask = irq_mask;
    next_bvalid   = s_axi_bvalid;
    next_bresp    = s_axi_bresp;
    next_rvalid   = s_axi_rvalid;
    next_rresp    = s_axi_rresp;
    next_rdata    = s_axi_rdata;
    w1c           = '0;
    wv            = '0;
    stat_word     = '0;
    for (int i = 0; i < N_IND; i++) begin
      stat_word[2*i +: 2] = st[i];
    end
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_hold && w_hold && !s_axi_bvalid) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      if (aw_addr == A_CTRL) begin
        wv         = apply_strb({31'h0, ctrl_setup}, w_data, w_strb);
        next_setup = wv[CTRL_SETUP_BIT];
      end else if (aw_addr == A_IRQ_STAT) begin
        wv  = apply_strb('0, w_data, w_strb);
        w1c = wv[IRQ_W-1:0];
      end else if (aw_addr == A_IRQ_MASK) begin
        wv            = apply_strb(32'(irq_mask), w_data, w_strb);
        next_irq_mask = wv[IRQ_W-1:0];
      end else if (!ctrl_setup) begin
        // settings are frozen outside setup, the write is refused
        next_bresp = RESP_SLVERR;
      end else if (aw_addr == A_SINGLE) begin
        wv          = apply_strb(32'(single), w_data, w_strb);
        next_single = wv[N_IND-1:0];
      end else if (aw_addr == A_EVMASK) begin
        wv          = apply_strb(32'(evmask), w_data, w_strb);
        next_evmask = wv[2*N_IND-1:0];
      end else if (is_name(aw_addr)) begin
        next_name[name_idx(aw_addr)] = apply_strb(name[name_idx(aw_addr)], w_data, w_strb);
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end
    // hardware set wins over a simultaneous write-one clear
    next_irq_stat = (irq_stat & ~w1c) | ev_set;
    next_irq      = |(next_irq_stat & next_irq_mask);
    rd_ok = 1'b1;
    rd    = '0;
    if (s_axi_araddr == A_CTRL) begin
      rd[CTRL_SETUP_BIT] = ctrl_setup;
    end else if (s_axi_araddr == A_SINGLE) begin
      rd = 32'(single);
    end else if (s_axi_araddr == A_EVMASK) begin
      rd = 32'(evmask);
    end else if (s_axi_araddr == A_STATUS) begin
      rd = stat_word;
    end else if (s_axi_araddr == A_IRQ_STAT) begin
      rd = 32'(irq_stat);
    end else if (s_axi_araddr == A_IRQ_MASK) begin
      rd = 32'(irq_mask);
    end else if (s_axi_araddr == A_TIME) begin
      rd = ms;
    end else if (is_name(s_axi_araddr)) begin
      rd = name[name_idx(s_axi_araddr)];
    end else begin
      rd_ok = 1'b0;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rd;
      next_rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      ctrl_setup    <= CTRL_SETUP_RST;
      single        <= '0;
      evmask        <= '1;
      irq_stat      <= '0;
      irq_mask      <= IRQ_MASK_RST;
      irq           <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= '0;
      for (int i = 0; i < NW; i++) begin
        name[i] <= DEFAULT_LABEL;
      end
    end else begin
      aw_hold       <= next_aw_hold;
      w_hold        <= next_w_hold;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      ctrl_setup    <= next_setup;
      single        <= next_single;
      evmask        <= next_evmask;
      name          <= next_name;
      irq_stat      <= next_irq_stat;
      irq_mask      <= next_irq_mask;
      irq           <= next_irq;
      s_axi_awready <= ~next_aw_hold & ~next_bvalid;
      s_axi_wready  <= ~next_w_hold & ~next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// ---- ism_gear_model.sv ----
/*
  Contact pair model of the monitored switchgear, one indicator per request.
  Assumes requests from the bench just after a rising edge of aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module ism_gear_model #(
  parameter int N = 10
) (
  input  wire logic         aclk,
  input  wire logic         go,
  input  wire logic [3:0]   idx,
  input  wire logic [1:0]   pos,
  input  wire logic         slow,
  output var  logic [N-1:0] open_in,
  output var  logic [N-1:0] close_in,
  output var  logic         busy
);
  int         cnt;
  logic [3:0] i_q;
  logic [1:0] p_q;
  initial begin
    open_in  = '0;
    close_in = '0;
    busy     = 1'b0;
  end
  // slow travel delays the contacts; both move on one edge so no false Bad
  always @(posedge aclk) begin
    if (go) begin
      busy <= 1'b1;
      cnt  <= slow ? 7 : 0;
      i_q  <= idx;
      p_q  <= pos;
    end else if (busy && cnt != 0) begin
      cnt <= cnt - 1;
    end else if (busy) begin
      open_in[i_q]  <= p_q[0];
      close_in[i_q] <= p_q[1];
      busy          <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- ism_top_monitor.sv ----
/*
  Port checker for ism_top: bus answer timing, event hand-off, reset quiet.
  Assumes it is bound into ism_top and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module ism_top_monitor #(
  parameter int N_IND = 10
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic              evt_valid,
  input wire logic              evt_ready,
  input wire ism_pkg::ism_evt_s evt
);
  import ism_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_released;
    $rose(aresetn);
  endsequence
  property p_wr_answer;
    s_wr_taken |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer not two cycles after take");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer not next cycle");
  property p_b_ready;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_ready: assert property (p_b_ready) else $error("write ready while response pending");
  property p_b_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_drop: assert property (p_b_drop) else $error("write response repeated");
  property p_evt_hold;
    evt_valid && !evt_ready |=> evt_valid && $stable(evt);
  endproperty
  a_evt_hold: assert property (p_evt_hold) else $error("event changed while stalled");
  property p_evt_drop;
    evt_valid && evt_ready |=> !evt_valid;
  endproperty
  a_evt_drop: assert property (p_evt_drop) else $error("event emitted twice");
  property p_evt_inst;
    evt_valid |-> evt.inst < N_IND;
  endproperty
  a_evt_inst: assert property (p_evt_inst) else $error("event from unknown indicator");
  // a false first-sample event would reach evt_valid on the fourth edge, so look past it
  property p_quiet;
    s_released |-> !evt_valid [*6];
  endproperty
  a_quiet: assert property (p_quiet) else $error("event right after reset");
endmodule
bind ism_top ism_top_monitor #(.N_IND(N_IND)) mon_u (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .evt_valid, .evt_ready, .evt
);
`default_nettype wire

// ---- ism_top_tb.sv ----
/*
  Self-checking bench for ism_top: register bus, decode, events, masks.
  Assumes ism_gear_model as the contact source and a short ms divider.
*/
`timescale 1ns/1ps
`default_nettype none
module ism_top_tb;
  import ism_pkg::*;
  localparam int TDIV = 20;
  logic             aclk, aresetn = 1'b0, irq, busy, evt_valid;
  logic [11:0]      s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]      s_axi_wdata = '0, s_axi_rdata, d, ex;
  logic [3:0]       s_axi_wstrb = 4'hF, idx = '0;
  logic             s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic             s_axi_rready = 0, evt_ready = 0, go = 0, slow = 0;
  logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]       s_axi_bresp, s_axi_rresp, r, p, pos = '0;
  logic [N_IND-1:0] open_in, close_in;
  ism_evt_s         evt, e1, e2;
  ism_status_e      st [N_IND];
  int               n_fail, check_count, cyc, tms, i;
  ism_top #(.TICK_DIV(TDIV)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .open_in, .close_in, .evt_valid, .evt_ready, .evt, .irq
  );
  ism_gear_model #(.N(N_IND)) gear_u (.aclk, .go, .idx, .pos, .slow, .open_in, .close_in, .busy);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= aresetn ? cyc + 1 : 0;
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [38:0] e, input logic [38:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic tmo(input logic ok);
    if (ok !== 1'b1) begin
      n_fail++;
      finish_test();
    end
  endtask
  // handshakes judged at the negedge, where registered readies are settled
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    int k;
    logic aw, w, b;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w  = s_axi_wvalid & s_axi_wready;
      b  = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (aw)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
      k++;
    end while (b !== 1'b1 && k < 50);
    s_axi_bready <= 1'b0;
    tmo(b);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    logic t, b;
    k = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge aclk);
      t  = s_axi_arvalid & s_axi_arready;
      b  = s_axi_rvalid;
      v  = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (t)
        s_axi_arvalid <= 1'b0;
      k++;
    end while (b !== 1'b1 && k < 50);
    s_axi_rready <= 1'b0;
    tmo(b);
  endtask
  task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    rd(a, d, r);
    chk(n, er, r);
    chk(n, e, d);
  endtask
  task automatic mv(input int k, input logic [1:0] ps);
    int n;
    n = 0;
    @(posedge aclk);
    go   <= 1'b1;
    idx  <= 4'(k);
    pos  <= ps;
    slow <= 1'($urandom_range(1));
    @(posedge aclk);
    go <= 1'b0;
    do begin
      @(negedge aclk);
      n++;
    end while (busy && n < 20);
    tmo(!busy);
    tms = cyc / TDIV;
  endtask
  // random stalls on the buffer side
  task automatic get_evt(output ism_evt_s ev);
    int k;
    logic t;
    k = 0;
    do begin
      @(posedge aclk);
      evt_ready <= 1'($urandom_range(1));
      @(negedge aclk);
      t  = evt_valid & evt_ready;
      ev = evt;
      k++;
    end while (t !== 1'b1 && k < 200);
    tmo(t);
    @(posedge aclk);
    evt_ready <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge aclk);
    tmo(1'b0);
  end
  initial begin
    void'($urandom(32'hF97B));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("ctrl", A_CTRL, 32'h0, RESP_OKAY);
    rchk("irq mask", A_IRQ_MASK, 32'h0, RESP_OKAY);
    rchk("status", A_STATUS, 32'h0, RESP_OKAY);
    rchk("name", 12'h23C, DEFAULT_LABEL, RESP_OKAY);
    rchk("unmapped", 12'hFFC, 32'h0, RESP_SLVERR);
    wr(A_EVMASK, 32'h0, r);
    chk("locked", RESP_SLVERR, r);
    rchk("evmask", A_EVMASK, 32'hFFFFF, RESP_OKAY);
    wr(A_IRQ_MASK, 32'h1, r);
    foreach (st[j]) st[j] = ST_INTER;
    for (int n = 0; n < 30; n++) begin
      i = n < 4 ? N_IND - 1 : $urandom_range(N_IND - 1);
      p = n < 4 ? 2'(n + 1) : 2'($urandom_range(3));
      mv(i, p);
      if (p != st[i]) begin
        get_evt(e1);
        get_evt(e2);
        chk("off", {4'(i), st[i], 1'b0}, e1[38:32]);
        chk("on", {4'(i), p, 1'b1}, e2[38:32]);
        chk("pair", e1.stamp, e2.stamp);
        chk("ms", 1, tms - int'(e1.stamp) inside {[-1:1]});
        st[i] = ism_status_e'(p);
      end
    end
    ex = '0;
    for (int j = 0; j < N_IND; j++) ex[2*j +: 2] = st[j];
    rchk("status", A_STATUS, ex, RESP_OKAY);
    chk("irq", 1, irq);
    // changes drained one by one and a Bad entered early: change and Bad set, no overrun
    rchk("irq stat", A_IRQ_STAT, 32'h3, RESP_OKAY);
    wr(A_IRQ_STAT, 32'h7, r);
    chk("irq clear", 0, irq);
    wr(A_CTRL, 32'h1, r);
    wr(A_EVMASK, 32'h1, r);
    wr(A_SINGLE, 32'h2, r);
    chk("setup", RESP_OKAY, r);
    d = $urandom();
    wr(A_NAME_BASE, d, r);
    rchk("name wr", A_NAME_BASE, d, RESP_OKAY);
    wr(A_CTRL, 32'h0, r);
    p = st[0] == ST_OPEN ? ST_CLOSED : ST_OPEN;
    mv(0, p);
    get_evt(e1);
    chk("on only", {4'h0, p, 1'b1}, e1[38:32]);
    mv(1, 2'b00);
    rd(A_STATUS, d, r);
    chk("single low", ST_CLOSED, d[3:2]);
    mv(1, 2'b11);
    rd(A_STATUS, d, r);
    chk("single high", ST_OPEN, d[3:2]);
    // a masked event would only appear a few cycles after the change
    repeat (4) @(negedge aclk);
    chk("masked", 0, evt_valid);
    // second reset with contacts away from Intermediate: no event from the first sample
    mv(2, 2'b01);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    ex = '0;
    for (int j = 0; j < N_IND; j++) ex[2*j +: 2] = {close_in[j], open_in[j]};
    repeat (8) begin
      @(negedge aclk);
      chk("quiet", 0, evt_valid);
    end
    rchk("status rst", A_STATUS, ex, RESP_OKAY);
    finish_test();
  end
endmodule
`default_nettype wire
